// ===== hw/adm_conv_tick.sv
// Purpose: converter clock enable, one pulse per converter clock period
// Assumes: divide ratios fit DIV_W bits
// Notes: restart realigns the phase so a conversion counts whole periods
`timescale 1ns/1ps
module adm_conv_tick import adm_pkg::*; #(
    parameter int unsigned SLOW_DIV = DIV_SLOW,
    parameter int unsigned FAST_DIV = DIV_FAST
) (
    input wire logic i_clk,     // system clock
    input wire logic i_rst_n,   // async reset, active low
    input wire logic i_fast,    // 1: fast converter rate
    input wire logic i_restart, // realign divider phase
    output logic o_tick         // one-cycle converter clock enable
);

    if (SLOW_DIV < 2 || FAST_DIV < 2 || SLOW_DIV > 2 ** DIV_W || FAST_DIV > 2 ** DIV_W) begin : g_bad_div
        $error("divide ratio out of range");
    end

    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] limit;

    assign limit = i_fast ? DIV_W'(FAST_DIV - 1) : DIV_W'(SLOW_DIV - 1);
    assign o_tick = !i_restart && (cnt_q >= limit);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
        end else if (i_restart || cnt_q >= limit) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

endmodule

// ===== hw/adm_measure_ctrl.sv
// Purpose: measurement source select, conversion sequencing, carrier detect
// Assumes: analog samples arrive as settled 8-bit codes; pins synchronous
// Notes: registers on a plain port, read data one cycle after the strobe
// Function
// - a conversion completes exactly 20 converter clock periods after its start.
// - the converter clock comes from the system clock at 800 kHz or 1.2 MHz by the clock select field.
// - outside receive with detect mode 0 and external select 0, writing start 1 begins a temperature conversion.
// - a single conversion clears the start bit when done and leaves its 8-bit result readable.
// - with both select bits 0 the result is signal strength in receive, temperature otherwise.
// - signal strength codes span 0 to 255, smaller meaning stronger.
// - in carrier detect the carrier pin is high while carrier strength exceeds the threshold.
// - receive with detect mode 1, external select 0 and start 1 measures repeatedly, refreshing each period until detection ends.
// - external select 1 with detect 1 in receive measures external input; other outside-receive uses are refused.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module adm_measure_ctrl import adm_pkg::*; #(
    parameter int unsigned SLOW_DIV = DIV_SLOW,
    parameter int unsigned FAST_DIV = DIV_FAST
) (
    input wire logic i_clk,                    // system clock, 125 MHz
    input wire logic i_rst_n,                  // async reset, active low
    input wire logic [ADDR_W-1:0] i_addr,      // register byte address
    input wire logic [DATA_W-1:0] i_wdata,     // write data
    input wire logic i_wr,                     // write strobe
    input wire logic i_rd,                     // read strobe
    output logic [DATA_W-1:0] o_rdata,         // read data, cycle after strobe
    input wire logic i_direction_select_pin,   // 0 selects receive
    input wire logic i_transceiver_enable_pin, // 1 enables transceiver
    input wire adm_samples_t i_samples,        // converter input codes
    output logic o_carrier_pin,                // carrier above threshold
    output logic o_irq                         // unmasked event pending
);

    function automatic adm_mode_t mode_of(input logic rx, input logic det, input logic ext);
        adm_mode_t m;
        m = MODE_NA;
        if (!ext && !det) begin
            m = rx ? MODE_RSSI : MODE_TEMP;
        end else if (!ext && det) begin
            m = rx ? MODE_CD : MODE_NA;
        end else if (ext && det) begin
            m = rx ? MODE_EXT : MODE_NA;
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic rx;
    logic start_q;
    logic detect_q;
    logic ext_q;
    logic [CLKSEL_W-1:0] clksel_q;
    logic fast_q;
    logic [7:0] thresh_q;
    logic [7:0] result_q;
    logic carrier_q;
    logic carrier_d;
    logic [IRQ_W-1:0] stat_q;
    logic [IRQ_W-1:0] mask_q;
    logic [IRQ_W-1:0] events;
    logic [DATA_W-1:0] rdata_q;
    logic [TCNT_W-1:0] tcnt_q;
    adm_state_t state_q;
    adm_mode_t mode_q;
    adm_mode_t start_mode;
    logic wr_ctrl;
    logic start_req;
    logic accept;
    logic reject;
    logic tick;
    logic conv_done;
    logic cd_end;
    logic [7:0] sample;

    assign rx = !i_direction_select_pin && i_transceiver_enable_pin;
    assign wr_ctrl = i_wr && (i_addr == OFS_CTRL);
    assign start_req = wr_ctrl && i_wdata[BIT_START];
    // source is judged from the bits written together with start
    assign start_mode = mode_of(rx, i_wdata[BIT_DETECT], i_wdata[BIT_EXT]);
    assign accept = start_req && (state_q == ST_IDLE) && (start_mode != MODE_NA);
    assign reject = start_req && (state_q == ST_IDLE) && (start_mode == MODE_NA);
    assign conv_done = (state_q != ST_IDLE) && tick && (tcnt_q == TCNT_W'(CONV_TICKS - 1));
    // detection ends when software drops start or detect, or receive is left
    assign cd_end = (wr_ctrl && (!i_wdata[BIT_START] || !i_wdata[BIT_DETECT])) || !rx;

    ////////////////////////////////////////////////////////////////////////
    // converter clock; rate latched at start so a busy conversion keeps it
    adm_conv_tick #(
        .SLOW_DIV(SLOW_DIV),
        .FAST_DIV(FAST_DIV)
    ) u_tick (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_fast(fast_q),
        .i_restart(accept),
        .o_tick(tick)
    );

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fast_q <= 1'b0;
        end else if (accept) begin
            fast_q <= i_wdata[CLKSEL_LSB];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tcnt_q <= '0;
        end else if (accept || conv_done) begin
            tcnt_q <= '0;
        end else if (state_q != ST_IDLE && tick) begin
            tcnt_q <= tcnt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
            mode_q <= MODE_NA;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        mode_q <= start_mode;
                        state_q <= (start_mode == MODE_CD) ? ST_CONT : ST_SINGLE;
                    end
                end
                ST_SINGLE: begin
                    if (conv_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_CONT: begin
                    if (cd_end) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            start_q <= 1'b0;
        end else if (accept) begin
            start_q <= 1'b1;
        end else if ((state_q == ST_SINGLE && conv_done) || (state_q == ST_CONT && cd_end)) begin
            start_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            detect_q <= 1'b0;
            ext_q <= 1'b0;
            clksel_q <= RST_CLKSEL;
            thresh_q <= RST_THRESH;
            mask_q <= RST_MASK;
        end else if (i_wr) begin
            if (i_addr == OFS_CTRL) begin
                detect_q <= i_wdata[BIT_DETECT];
                ext_q <= i_wdata[BIT_EXT];
                clksel_q <= i_wdata[CLKSEL_LSB +: CLKSEL_W];
            end
            if (i_addr == OFS_THRESH) begin
                thresh_q <= i_wdata[7:0];
            end
            if (i_addr == OFS_IRQ_MASK) begin
                mask_q <= i_wdata[IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strength codes pass unchanged: the front end already runs inverse to power
    always_comb begin
        unique case (mode_q)
            MODE_TEMP: sample = i_samples.temp;
            MODE_EXT: sample = i_samples.ext;
            default: sample = i_samples.rssi;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            result_q <= RST_RESULT;
        end else if (conv_done) begin
            result_q <= sample;
        end
    end

    // carrier strength is the complement of the inverse strength code
    always_comb begin
        carrier_d = carrier_q;
        if (state_q != ST_CONT) begin
            carrier_d = 1'b0;
        end else if (conv_done) begin
            carrier_d = (8'hff - i_samples.rssi) > thresh_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            carrier_q <= 1'b0;
        end else begin
            carrier_q <= carrier_d;
        end
    end

    assign o_carrier_pin = carrier_q;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        events = '0;
        events[IRQ_DONE] = conv_done && (state_q == ST_SINGLE);
        events[IRQ_REFRESH] = conv_done && (state_q == ST_CONT);
        events[IRQ_CARRIER] = carrier_d != carrier_q;
        events[IRQ_REJECT] = reject;
    end

    // a new event in the clearing read's cycle survives the clear
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stat_q <= '0;
        end else if (i_rd && i_addr == OFS_IRQ_STAT) begin
            stat_q <= events;
        end else begin
            stat_q <= stat_q | events;
        end
    end

    assign o_irq = |(stat_q & mask_q);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q <= '0;
        end else if (i_rd) begin
            unique case (i_addr)
                OFS_CTRL: rdata_q <= DATA_W'({clksel_q, 5'h00, ext_q, detect_q, start_q});
                OFS_THRESH: rdata_q <= DATA_W'(thresh_q);
                OFS_RESULT: rdata_q <= DATA_W'({carrier_q, state_q != ST_IDLE, result_q});
                OFS_IRQ_STAT: rdata_q <= DATA_W'(stat_q);
                OFS_IRQ_MASK: rdata_q <= DATA_W'(mask_q);
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign o_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // cycles since the accepted start, for timing checks
    logic [CYC_W-1:0] cyc_q;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cyc_q <= '0;
        end else if (accept) begin
            cyc_q <= CYC_W'(1);
        end else if (state_q != ST_IDLE) begin
            cyc_q <= cyc_q + 1'b1;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_temp_start;
        start_req && state_q == ST_IDLE && !rx && !i_wdata[BIT_DETECT] && !i_wdata[BIT_EXT];
    endsequence

    sequence s_single_running;
        state_q == ST_SINGLE && start_q;
    endsequence

    property p_conv_time;
        conv_done && state_q == ST_SINGLE |-> cyc_q == (fast_q ? CYC_W'(CONV_TICKS * FAST_DIV)
                                                               : CYC_W'(CONV_TICKS * SLOW_DIV));
    endproperty
    a_conv_time: assert property (p_conv_time) else $error("conversion length wrong");

    property p_rate;
        accept |=> fast_q == $past(i_wdata[CLKSEL_LSB]);
    endproperty
    a_rate: assert property (p_rate) else $error("converter rate not taken");

    property p_temp_start;
        s_temp_start |=> s_single_running ##0 mode_q == MODE_TEMP;
    endproperty
    a_temp_start: assert property (p_temp_start) else $error("temperature start lost");

    property p_single_done;
        conv_done && state_q == ST_SINGLE |=> !start_q && state_q == ST_IDLE && result_q == $past(sample);
    endproperty
    a_single_done: assert property (p_single_done) else $error("start not cleared at done");

    property p_rx_rssi;
        accept && rx && !i_wdata[BIT_DETECT] && !i_wdata[BIT_EXT] |=> mode_q == MODE_RSSI;
    endproperty
    a_rx_rssi: assert property (p_rx_rssi) else $error("receive source not strength");

    property p_carrier;
        state_q == ST_CONT && conv_done |=>
            o_carrier_pin == ((8'hff - $past(i_samples.rssi)) > $past(thresh_q));
    endproperty
    a_carrier: assert property (p_carrier) else $error("carrier pin wrong");

    property p_cont_refresh;
        state_q == ST_CONT && conv_done && !cd_end |=> state_q == ST_CONT && tcnt_q == '0 && start_q;
    endproperty
    a_cont_refresh: assert property (p_cont_refresh) else $error("detection stopped early");

    property p_na_refused;
        reject |=> state_q == ST_IDLE && !start_q && stat_q[IRQ_REJECT];
    endproperty
    a_na_refused: assert property (p_na_refused) else $error("invalid source accepted");

    property p_busy_ignore;
        start_req ##0 s_single_running |=> cyc_q == $past(cyc_q) + 1'b1;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("busy start restarted count");

endmodule

// ===== hw/adm_pkg.sv
// Purpose: shared constants and types for the converter measurement control
// Assumes: 125 MHz system clock, 32-bit plain register port
// Notes: offsets are byte addresses, one aligned word per register
package adm_pkg;

    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned CONV_SLOW_HZ = 800_000;
    localparam int unsigned CONV_FAST_HZ = 1_200_000;
    localparam int unsigned DIV_SLOW = CLK_HZ / CONV_SLOW_HZ;
    localparam int unsigned DIV_FAST = CLK_HZ / CONV_FAST_HZ;
    localparam int unsigned CONV_TICKS = 20;
    localparam int DIV_W = 8;
    localparam int TCNT_W = 5;
    localparam int CYC_W = 16;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_THRESH = 8'h04;
    localparam logic [7:0] OFS_RESULT = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

    // control word layout
    localparam int BIT_START = 0;
    localparam int BIT_DETECT = 1;
    localparam int BIT_EXT = 2;
    localparam int CLKSEL_LSB = 8;
    localparam int CLKSEL_W = 5;
    // result word layout
    localparam int BIT_BUSY = 8;
    localparam int BIT_CARRIER = 9;
    // interrupt status / mask layout
    localparam int IRQ_W = 4;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_REFRESH = 1;
    localparam int IRQ_CARRIER = 2;
    localparam int IRQ_REJECT = 3;

    localparam logic [7:0] RST_THRESH = 8'h00;
    localparam logic [7:0] RST_RESULT = 8'h00;
    localparam logic [4:0] RST_CLKSEL = 5'h00;
    localparam logic [3:0] RST_MASK = 4'h0;

    typedef struct packed {
        logic [7:0] temp;
        logic [7:0] rssi;
        logic [7:0] ext;
    } adm_samples_t;

    typedef enum logic [1:0] {ST_IDLE, ST_SINGLE, ST_CONT} adm_state_t;
    typedef enum logic [2:0] {MODE_NA, MODE_TEMP, MODE_RSSI, MODE_CD, MODE_EXT} adm_mode_t;

endpackage

// ===== tb/adm_radio_model.sv
// Purpose: radio front end facing the measurement block: mode pins and converter codes
// Assumes: pins change just after the system clock edge
// Notes: standby holds direction high and enable low
`timescale 1ns/1ps
module adm_radio_model import adm_pkg::*; (
    input wire logic i_clk,         // system clock
    input wire logic i_rx_want,     // 1: sit in receive
    input wire logic [7:0] i_temp,  // temperature code
    input wire logic [7:0] i_rssi,  // strength code, smaller is stronger
    input wire logic [7:0] i_ext,   // external input code
    output logic o_dir,             // direction pin
    output logic o_en,              // transceiver enable pin
    output adm_samples_t o_samples  // codes to converter
);
    initial begin
        o_dir = 1'b1;
        o_en = 1'b0;
        o_samples = '0;
    end
    // receive is direction low with enable high, standby is enable low
    always @(posedge i_clk) begin
        o_dir <= !i_rx_want;
        o_en <= i_rx_want;
        o_samples <= '{temp: i_temp, rssi: i_rssi, ext: i_ext};
    end
endmodule

// ===== tb/tb_top.sv
// Purpose: self-checking bench for the measurement control block
// Assumes: shortened converter dividers, 125 MHz clock
// Notes: done timing is measured on the interrupt output
`timescale 1ns/1ps
module tb_top import adm_pkg::*;;
    localparam int SD = 4;
    localparam int FD = 3;
    logic i_clk, i_rst_n, wr, rd, rx_want, carrier, irq, dir, en;
    logic [7:0] addr, temp, rssi, ext;
    logic [31:0] wdata, rdata, d;
    adm_samples_t smp;
    int error_cnt = 0;
    int n_compared = 0;
    int n;
    typedef struct {logic rx; logic [31:0] ctrl; logic [7:0] res; int div;} row_t;
    row_t rows[4] = '{'{1'b0, 32'h001, 8'h5a, SD}, '{1'b0, 32'h101, 8'h5a, FD},
                      '{1'b1, 32'h001, 8'h33, SD}, '{1'b1, 32'h007, 8'hc4, SD}};

    adm_measure_ctrl #(.SLOW_DIV(SD), .FAST_DIV(FD)) i_adm_measure_ctrl (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_direction_select_pin(dir), .i_transceiver_enable_pin(en),
        .i_samples(smp), .o_carrier_pin(carrier), .o_irq(irq));
    adm_radio_model i_adm_radio_model (
        .i_clk(i_clk), .i_rx_want(rx_want), .i_temp(temp), .i_rssi(rssi), .i_ext(ext),
        .o_dir(dir), .o_en(en), .o_samples(smp));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    // counts edges from the taking edge until the interrupt is seen
    task automatic wait_irq(output int cnt);
        cnt = 0;
        while (irq !== 1'b1) begin
            @(posedge i_clk);
            #1;
            cnt++;
            if (cnt > 1000) begin
                error_cnt++;
                $display("[FAIL] irq wait expected 1 seen timeout");
                tally_and_finish();
            end
        end
    endtask
    task automatic pins(input logic r);
        rx_want <= r;
        repeat (3) @(posedge i_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_rst_n = 1'b0;
        {wr, rd, rx_want} = '0;
        addr = '0;
        wdata = '0;
        temp = 8'h5a;
        rssi = 8'h33;
        ext = 8'hc4;
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        foreach (rows[k]) begin
            rd_reg(8'h00 + 8'(k * 4), d);
            check("reset reg", d, 32'h0);
        end
        wr_reg(8'h14, 32'hffff_ffff);
        rd_reg(8'h14, d);
        check("unmapped", d, 32'h0);
        $display("test reset_and_map done");

        wr_reg(OFS_IRQ_MASK, 32'h9);
        foreach (rows[k]) begin
            pins(rows[k].rx);
            wr_reg(OFS_CTRL, rows[k].ctrl);
            wait_irq(n);
            check("done cycles", 32'(n == 20 * rows[k].div || n == 20 * rows[k].div + 1), 32'h1);
            rd_reg(OFS_RESULT, d);
            check("result", d, {24'h0, rows[k].res});
            rd_reg(OFS_CTRL, d);
            check("start cleared", 32'(d[0]), 32'h0);
            rd_reg(OFS_IRQ_STAT, d);
            check("done status", d, 32'h1);
            check("irq after clear", 32'(irq), 32'h0);
        end
        $display("test source_table done");

        pins(1'b0);
        wr_reg(OFS_CTRL, 32'h1);
        repeat (10) @(posedge i_clk);
        wr_reg(OFS_CTRL, 32'h1);
        wait_irq(n);
        check("no restart", 32'(n + 12 == 20 * SD || n + 12 == 20 * SD + 1), 32'h1);
        rd_reg(OFS_IRQ_STAT, d);
        check("busy done status", d, 32'h1);
        $display("test start_while_busy done");

        wr_reg(OFS_IRQ_MASK, 32'h1);
        pins(1'b1);
        wr_reg(OFS_CTRL, 32'h5);
        repeat (3) @(posedge i_clk);
        check("masked reject irq", 32'(irq), 32'h0);
        rd_reg(OFS_IRQ_STAT, d);
        check("reject status", d, 32'h8);
        wr_reg(OFS_IRQ_MASK, 32'h9);
        pins(1'b0);
        wr_reg(OFS_CTRL, 32'h3);
        wait_irq(n);
        rd_reg(OFS_CTRL, d);
        check("refused start", 32'(d[0]), 32'h0);
        rd_reg(OFS_IRQ_STAT, d);
        check("reject status rx0", d, 32'h8);
        $display("test refusal done");

        // strength equal to threshold must stay low: the compare is strict
        wr_reg(OFS_IRQ_MASK, 32'h2);
        wr_reg(OFS_THRESH, 32'h40);
        rssi <= 8'hbf;
        pins(1'b1);
        wr_reg(OFS_CTRL, 32'h3);
        wait_irq(n);
        check("period", 32'(n == 20 * SD || n == 20 * SD + 1), 32'h1);
        check("pin at threshold", 32'(carrier), 32'h0);
        rd_reg(OFS_IRQ_STAT, d);
        check("refresh status", d, 32'h2);
        rssi <= 8'h10;
        wait_irq(n);
        check("pin strong", 32'(carrier), 32'h1);
        rd_reg(OFS_RESULT, d);
        // busy stays set for the whole detection run
        check("detect result", d, 32'h310);
        rd_reg(OFS_IRQ_STAT, d);
        check("change status", d, 32'h6);
        pins(1'b0);
        // pin falls two edges after receive is left; look once it has settled
        #1;
        check("pin after rx", 32'(carrier), 32'h0);
        rd_reg(OFS_CTRL, d);
        check("detect ended", 32'(d[0]), 32'h0);
        // detection also ends when software drops start
        pins(1'b1);
        wr_reg(OFS_CTRL, 32'h3);
        repeat (5) @(posedge i_clk);
        wr_reg(OFS_CTRL, 32'h2);
        rd_reg(OFS_CTRL, d);
        check("stop by write", 32'(d[0]), 32'h0);
        rd_reg(OFS_RESULT, d);
        check("idle after stop", d, 32'h10);
        pins(1'b0);
        $display("test carrier_detect done");

        wr_reg(OFS_IRQ_MASK, 32'h1);
        wr_reg(OFS_CTRL, 32'h1);
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b0;
        @(posedge i_clk);
        #1;
        check("rst rdata", rdata, 32'h0);
        check("rst irq", 32'(irq), 32'h0);
        check("rst pin", 32'(carrier), 32'h0);
        i_rst_n <= 1'b1;
        rd_reg(OFS_CTRL, d);
        check("rst ctrl", d, 32'h0);
        rd_reg(OFS_IRQ_MASK, d);
        check("rst mask", d, 32'h0);
        $display("test mid_reset done");
        tally_and_finish();
    end
endmodule
